// *** hdl/ccs_map.svh ***
// ccs_map.svh: offsets, field positions, reset values and delay counts of the clock selector
// assumes a 10 MHz pclk; the includer provides `timescale where needed
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH
`define CCS_CLOCK_CONFIGURATION_OFF 12'hf8
`define CCS_CLOCK_CONFIGURATION_RST 8'h00
`define CCS_BIT_RESUME_DELAY 7
`define CCS_BIT_WAKE_HI 6
`define CCS_BIT_WAKE_LO 4
`define CCS_BIT_UV_DISABLE 3
`define CCS_BIT_PRECISION 2
`define CCS_BIT_CLKOUT_DIS 1
`define CCS_BIT_EXT_ENABLE 0
`define CCS_STATUS_OFF 12'h0fc
`define CCS_PCLK_MHZ 10
`define CCS_SHORT_DELAY_US 128
`define CCS_LONG_DELAY_US 4000
`define CCS_INT_RESUME_US 8
`define CCS_SETTLE_US 500
`define CCS_SHORT_CYC (`CCS_SHORT_DELAY_US * `CCS_PCLK_MHZ)
`define CCS_LONG_CYC (`CCS_LONG_DELAY_US * `CCS_PCLK_MHZ)
`define CCS_INT_RESUME_CYC (`CCS_INT_RESUME_US * `CCS_PCLK_MHZ)
`define CCS_SETTLE_CYC (`CCS_SETTLE_US * `CCS_PCLK_MHZ)
`endif

// *** hdl/ccs_pkg.sv ***
// ccs_pkg: types shared by the clock source selector
// assumes nothing beyond a SystemVerilog compiler
package ccs_pkg;
  typedef enum logic [2:0] {
    CCS_RUN = 3'b000,
    CCS_OSC_START = 3'b001,
    CCS_RESUME_WAIT = 3'b011,
    CCS_SETTLE = 3'b010,
    CCS_SUSPENDED = 3'b110
  } ccs_state_t;
  typedef struct packed {
    logic resume_delay;
    logic [2:0] wake_period;
    logic uv_disable;
    logic precision;
    logic clkout_dis;
    logic ext_enable;
  } ccs_cfg_t;
endpackage

// *** hdl/ccs_clock_select.sv ***
// ccs_clock_select: clock source selection, halt and resume sequencing, APB registers
// assumes pclk 10 MHz, presetn asynchronous active low, APB master per AMBA 3
// Overview of operation
// - resume delay bit picks external delay
// - hold 128 us or 4 ms after stable
// - internal wake adds only 8 us
// - three-bit field sets wake-up period
// - disable bit turns undervoltage restart off
// - undervoltage low: settle interval, restart at zero
// - precision bit tunes internal clock from USB
// - clock output disable drives output high while on the internal clock
// - after power-up internal clock, buffered out
// - external enable write halts, stops internal
// - stable external clock, then resume delay
// - clearing external enable waits for wake
// - return to internal only on wake or undervoltage restart
// - internal 6 MHz oscillator used from reset
// - crystal input read as aux input bit while on the internal clock, forced low in external mode
// - undervoltage restart forces internal, then settles
`timescale 1ns/1ps
`include "ccs_map.svh"
module ccs_clock_select #(
  parameter int unsigned LONG_CYC = `CCS_LONG_CYC,
  parameter int unsigned SETTLE_CYC = `CCS_SETTLE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_osc_clk,
  input wire logic ext_osc_stable,
  input wire logic crystal_input_pin,
  input wire logic supply_low,
  input wire logic suspend_req,
  input wire logic wake_event,
  input wire logic usb_traffic_seen,
  output logic crystal_output_pin,
  output logic crystal_input_pulldown,
  output logic int_osc_enable,
  output logic ext_osc_enable,
  output logic core_clk_ext,
  output logic core_halt,
  output logic restart_at_zero,
  output logic undervoltage_restart,
  output logic precision_tune,
  output logic [2:0] wake_period,
  output logic aux_input_bit_one
);
  localparam int unsigned CNT_W = 32;
  localparam int unsigned SHORT_CYC = `CCS_SHORT_CYC;
  localparam int unsigned INT_CYC = `CCS_INT_RESUME_CYC;

  // two-flop synchronisers; first stage read only by the second
  logic [3:0] sync1, sync2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= {ext_osc_stable, crystal_input_pin, supply_low, int_osc_clk};
      sync2 <= sync1;
    end
  end
  logic stable_s, xin_s, low_s, iclk_s;
  assign {stable_s, xin_s, low_s, iclk_s} = sync2;

  // apb decode; zero wait states, unmapped reads zero with pslverr
  logic acc, hit_cfg, hit_sts;
  assign acc = psel && penable;
  assign hit_cfg = paddr == `CCS_CLOCK_CONFIGURATION_OFF;
  assign hit_sts = paddr == `CCS_STATUS_OFF;

  ccs_pkg::ccs_cfg_t cfg, next_cfg;
  ccs_pkg::ccs_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic ext_mode, next_ext_mode;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  // register file and bus answer
  always_comb begin
    next_cfg = cfg;
    next_prdata = 32'h0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (psel && !penable) begin
      next_pready = 1'b1;
      next_pslverr = !(hit_cfg || hit_sts);
      if (hit_cfg) begin
        next_prdata = {24'h0, cfg};
      end else if (hit_sts) begin
        next_prdata = {27'h0, state, ext_mode, core_halt};
      end
    end
    if (acc && pready && pwrite && hit_cfg) begin
      next_cfg = ccs_pkg::ccs_cfg_t'(pwdata[7:0]);
    end
    if (low_s && !cfg.uv_disable) begin
      next_cfg.ext_enable = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= ccs_pkg::ccs_cfg_t'(`CCS_CLOCK_CONFIGURATION_RST);
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  logic ext_write;
  assign ext_write = acc && pready && pwrite && hit_cfg && pwdata[`CCS_BIT_EXT_ENABLE];

  // source sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ext_mode = ext_mode;
    unique case (state)
      ccs_pkg::CCS_RUN: begin
        if (ext_write && !ext_mode) begin
          next_state = ccs_pkg::CCS_OSC_START;
        end else if (suspend_req) begin
          next_state = ccs_pkg::CCS_SUSPENDED;
        end
      end
      ccs_pkg::CCS_OSC_START: begin
        if (stable_s) begin
          next_ext_mode = 1'b1;
          next_state = ccs_pkg::CCS_RESUME_WAIT;
          // pick 128 us or 4 ms
          next_cnt = cfg.resume_delay ? LONG_CYC : SHORT_CYC;
        end
      end
      ccs_pkg::CCS_RESUME_WAIT: begin
        if (cnt <= 1) begin
          next_state = ccs_pkg::CCS_RUN;
          next_cnt = '0;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ccs_pkg::CCS_SUSPENDED: begin
        if (wake_event) begin
          if (cfg.ext_enable) begin
            next_state = ccs_pkg::CCS_OSC_START;
          end else begin
            next_ext_mode = 1'b0;
            next_state = ccs_pkg::CCS_RESUME_WAIT;
            next_cnt = INT_CYC;
          end
        end
      end
      ccs_pkg::CCS_SETTLE: begin
        if (low_s) begin
          next_cnt = SETTLE_CYC;
        end else if (cnt <= 1) begin
          next_state = ccs_pkg::CCS_RUN;
          next_cnt = '0;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: next_state = ccs_pkg::CCS_RUN;
    endcase
    if (low_s && !cfg.uv_disable) begin
      next_state = ccs_pkg::CCS_SETTLE;
      next_ext_mode = 1'b0;
      next_cnt = SETTLE_CYC;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ccs_pkg::CCS_RUN;
      cnt <= '0;
      ext_mode <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ext_mode <= next_ext_mode;
    end
  end

  // registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crystal_output_pin <= 1'b0;
      crystal_input_pulldown <= 1'b1;
      int_osc_enable <= 1'b1;
      ext_osc_enable <= 1'b0;
      core_clk_ext <= 1'b0;
      core_halt <= 1'b0;
      restart_at_zero <= 1'b0;
      undervoltage_restart <= 1'b1;
      precision_tune <= 1'b0;
      wake_period <= 3'h0;
      aux_input_bit_one <= 1'b0;
    end else begin
      // output high or internal clock; external mode leaves it low
      crystal_output_pin <= next_ext_mode ? 1'b0 : (cfg.clkout_dis | iclk_s);
      crystal_input_pulldown <= !next_ext_mode;
      aux_input_bit_one <= next_ext_mode ? 1'b0 : xin_s;
      int_osc_enable <= !(next_ext_mode || next_state == ccs_pkg::CCS_OSC_START);
      ext_osc_enable <= next_ext_mode || next_state == ccs_pkg::CCS_OSC_START;
      core_clk_ext <= next_ext_mode;
      core_halt <= next_state != ccs_pkg::CCS_RUN;
      restart_at_zero <= state == ccs_pkg::CCS_SETTLE && next_state == ccs_pkg::CCS_RUN;
      undervoltage_restart <= !next_cfg.uv_disable;
      precision_tune <= cfg.precision && !next_ext_mode && usb_traffic_seen;
      wake_period <= cfg.wake_period;
    end
  end

  // core halted whenever the clock source changes
  clk_switch_halted_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(ext_mode) |-> state != ccs_pkg::CCS_RUN)
    else $error("source switch while running");
  // halt and oscillator handover show on the edge after the write
  ext_write_halts_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ccs_pkg::CCS_RUN && ext_write && !ext_mode && !(low_s && !cfg.uv_disable))
    |=> core_halt && !int_osc_enable && ext_osc_enable)
    else $error("external enable did not halt");
  short_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ccs_pkg::CCS_OSC_START && stable_s && !cfg.resume_delay && !low_s)
    |=> cnt == SHORT_CYC)
    else $error("short resume delay wrong");
  long_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ccs_pkg::CCS_OSC_START && stable_s && cfg.resume_delay && !low_s)
    |=> cnt == LONG_CYC)
    else $error("long resume delay wrong");
  int_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ccs_pkg::CCS_SUSPENDED && wake_event && !cfg.ext_enable && !low_s)
    |=> cnt == INT_CYC && !ext_mode)
    else $error("internal wake delay wrong");
  no_direct_return_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(ext_mode) |-> $past(state) inside {ccs_pkg::CCS_SUSPENDED, ccs_pkg::CCS_SETTLE}
    || ($past(low_s) && !$past(cfg.uv_disable)))
    else $error("internal mode without wake");
  uv_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    (low_s && !cfg.uv_disable) |=> state == ccs_pkg::CCS_SETTLE && !ext_mode)
    else $error("undervoltage restart missing");
  // the bit has no say once the core clock switches to the external oscillator
  clkout_high_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.clkout_dis && !ext_mode && !$changed(ext_mode))
    |=> (crystal_output_pin || ext_mode))
    else $error("clock output not held high");
  // external switch: clocks move over first, resume delay runs after
  sequence osc_ready_s;
    state == ccs_pkg::CCS_OSC_START && stable_s && !(low_s && !cfg.uv_disable);
  endsequence
  sequence ext_resume_s;
    state == ccs_pkg::CCS_RESUME_WAIT && core_clk_ext && core_halt;
  endsequence
  ext_resume_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    osc_ready_s |=> ext_resume_s)
    else $error("external resume order wrong");
  // settle countdown ends in one restart pulse with the core released
  sequence settle_done_s;
    state == ccs_pkg::CCS_SETTLE && !low_s && cnt <= 1;
  endsequence
  sequence restart_s;
    restart_at_zero && !core_halt && !core_clk_ext;
  endsequence
  settle_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
    settle_done_s |=> restart_s)
    else $error("restart after settle missing");
  // configuration fields reach their outputs
  uv_enable_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    undervoltage_restart == !cfg.uv_disable)
    else $error("undervoltage restart enable wrong");
  wake_period_out_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake_period == $past(cfg.wake_period))
    else $error("wake period field wrong");
  // external mode: no tuning, crystal input no longer a plain input
  ext_mode_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
    core_clk_ext |-> !aux_input_bit_one && !crystal_input_pulldown && !precision_tune)
    else $error("external mode pin state wrong");
  // clearing the enable while external keeps the external clock
  ext_clear_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ccs_pkg::CCS_RUN && ext_mode && acc && pready && pwrite && hit_cfg
    && !pwdata[`CCS_BIT_EXT_ENABLE] && !(low_s && !cfg.uv_disable)) |=> ext_mode)
    else $error("clearing enable left external mode");
endmodule

// *** test/ccs_osc_model.sv ***
// ccs_osc_model: resonator or crystal hanging on the crystal pins
// assumes pclk as a time base; the output pin is never loaded
`timescale 1ns/1ps
module ccs_osc_model #(
  parameter int START_CYC = 30
) (
  input wire logic pclk,
  input wire logic ext_osc_enable,
  input wire logic gpio_en,
  input wire logic gpio_level,
  output logic ext_osc_stable = 1'b0,
  output logic crystal_input_pin
);
  int cnt = 0;
  logic swing = 1'b0;
  // start-up time, output pin left open
  always @(posedge pclk) begin
    swing <= ~swing;
    cnt <= ext_osc_enable ? ((cnt < START_CYC) ? cnt + 1 : cnt) : 0;
    ext_osc_stable <= ext_osc_enable && (cnt >= START_CYC);
  end
  // weak pull-down wins when nothing drives; the running resonator swings
  assign crystal_input_pin = ext_osc_enable ? swing : (gpio_en ? gpio_level : 1'b0);
endmodule

// *** test/clock_source_select_control_test.sv ***
// clock_source_select_control_test: directed bench for the clock selector
// assumes zero-wait apb slave and the oscillator model beside it
`timescale 1ns/1ps
`include "ccs_map.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module clock_source_select_control_test;
  localparam int LONG = 50;
  localparam int SETTLE = 20;
  localparam logic [11:0] CFG = `CCS_CLOCK_CONFIGURATION_OFF;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, int_osc_clk = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, ext_osc_stable, crystal_input_pin, gpio_en = 0, gpio_level = 0;
  logic supply_low = 0, suspend_req = 0, wake_event = 0, usb_traffic_seen = 0;
  logic crystal_output_pin, crystal_input_pulldown, int_osc_enable, ext_osc_enable;
  logic core_clk_ext, core_halt, restart_at_zero, undervoltage_restart, precision_tune;
  logic aux_input_bit_one;
  logic [2:0] wake_period;
  int fail_count = 0, n_tests = 0, n;
  ccs_clock_select #(.LONG_CYC(LONG), .SETTLE_CYC(SETTLE)) ccs_clock_select_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .int_osc_clk, .ext_osc_stable, .crystal_input_pin, .supply_low, .suspend_req,
    .wake_event, .usb_traffic_seen, .crystal_output_pin, .crystal_input_pulldown,
    .int_osc_enable, .ext_osc_enable, .core_clk_ext, .core_halt, .restart_at_zero,
    .undervoltage_restart, .precision_tune, .wake_period, .aux_input_bit_one);
  ccs_osc_model ccs_osc_model_inst (.pclk, .ext_osc_enable, .gpio_en, .gpio_level,
    .ext_osc_stable, .crystal_input_pin);
  // internal oscillator runs unrelated to pclk, as the selector samples it as data
  initial forever #50 pclk = ~pclk;
  initial forever #83 int_osc_clk = ~int_osc_clk;
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  // counts cycles until the watched output reaches v; a hang ends the run
  task automatic wait_on(input int w, input logic v);
    logic s;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      s = (w == 0) ? core_halt : ((w == 1) ? core_clk_ext : restart_at_zero);
    end while (s !== v && n < 3000);
    if (s !== v) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  function automatic logic near(int m, int e);
    return m >= e - 12 && m <= e + 12;
  endfunction
  task automatic t_reset;
    apb(0, CFG, 0);
    `CHK(rd, 32'h0)
    `CHK({int_osc_enable, ext_osc_enable, core_clk_ext, core_halt}, 4'b1000)
    apb(0, 12'h040, 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("reset test done");
  endtask
  task automatic t_fields;
    // tuning only shows once usb traffic has been seen
    usb_traffic_seen <= 1;
    apb(1, CFG, 32'h7e);
    repeat (3) @(posedge pclk);
    `CHK({wake_period, undervoltage_restart}, 4'b1110)
    `CHK({precision_tune, crystal_output_pin}, 2'b11)
    apb(0, CFG, 0);
    `CHK(rd, 32'h7e)
    apb(1, CFG, 32'h0);
    n = 0;
    repeat (20) begin @(posedge pclk); n += (crystal_output_pin === 1'b1); end
    `CHK(n > 0 && n < 20, 1'b1)
    `CHK({undervoltage_restart, precision_tune}, 2'b10)
    gpio_en <= 1;
    gpio_level <= 1;
    repeat (5) @(posedge pclk);
    `CHK({aux_input_bit_one, crystal_input_pulldown}, 2'b11)
    gpio_en <= 0;
    $display("fields test done");
  endtask
  task automatic t_switch(input logic [7:0] v, input int e);
    apb(1, CFG, {24'h0, v});
    repeat (3) @(posedge pclk);
    `CHK({core_halt, ext_osc_enable, int_osc_enable}, 3'b110)
    wait_on(1, 1'b1);
    `CHK(core_halt, 1'b1)
    wait_on(0, 1'b0);
    `CHK(near(n, e), 1'b1)
    $display("switch test done");
  endtask
  task automatic t_wake;
    apb(1, CFG, 32'h80);
    repeat (10) @(posedge pclk);
    `CHK(core_clk_ext, 1'b1)
    suspend_req <= 1;
    @(posedge pclk);
    suspend_req <= 0;
    repeat (5) @(posedge pclk);
    wake_event <= 1;
    @(posedge pclk);
    wake_event <= 0;
    wait_on(0, 1'b0);
    `CHK(near(n, `CCS_INT_RESUME_CYC), 1'b1)
    `CHK({core_clk_ext, int_osc_enable}, 2'b01)
    $display("wake test done");
  endtask
  task automatic t_uv;
    supply_low <= 1;
    repeat (6) @(posedge pclk);
    `CHK({ext_osc_enable, int_osc_enable, core_halt}, 3'b011)
    apb(0, CFG, 0);
    `CHK(rd[0], 1'b0)
    supply_low <= 0;
    wait_on(2, 1'b1);
    `CHK(near(n, SETTLE), 1'b1)
    `CHK(core_clk_ext, 1'b0)
    $display("undervoltage test done");
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_fields();
    t_switch(8'h81, LONG);
    t_wake();
    t_switch(8'h01, `CCS_SHORT_CYC);
    t_uv();
    tally_and_finish();
  end
endmodule
